// >>> dv/pwm_load.sv
// partner: load on one pwm pin, times high phase and period
`timescale 1ns/1ps
`default_nettype none
module pwm_load (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// pin and measurements
	input  wire logic        pin,
	output logic      [15:0] high_len,
	output logic      [15:0] period
);
	logic [15:0] age_q;
	logic        pin_q;
	// age restarts at each rising edge of the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			age_q <= 16'h0;
			pin_q <= 1'b0;
			high_len <= 16'h0;
			period <= 16'h0;
		end else begin
			pin_q <= pin;
			age_q <= (pin && !pin_q) ? 16'h1 : age_q + 16'h1;
			if (pin && !pin_q)
				period <= age_q;
			if (!pin && pin_q)
				high_len <= age_q;
		end
	end
endmodule
`default_nettype wire

// >>> dv/pwm_timer_asserts.sv
// checker: port-level properties of the pwm timer
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_asserts (
	// clock, reset and register port
	input wire logic                         clk,
	input wire logic                         rst_n,
	input wire logic [pwm_pkg::ADDR_W-1:0]   addr,
	input wire logic [31:0]                  wdata,
	input wire logic                         wr,
	input wire logic                         rd,
	input wire logic [31:0]                  rdata,
	// pins and requests
	input wire logic [pwm_pkg::NUM_OUT-1:0]  chan1_out,
	input wire logic [pwm_pkg::NUM_OUT-1:0]  chan2_out,
	input wire logic [pwm_pkg::NUM_CHAN-1:0] match_req
);
	import pwm_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// request standing two cycles
	sequence s_req_held; match_req[0] [*2]; endsequence
	property p_far; rd && addr[7:6] != 2'h0 |=> rdata == 32'h0; endproperty
	a_far: assert property (p_far) else $error("far read nonzero");
	property p_ie0;
		wr && addr == 8'h00 && !wdata[CTRL_IE] |-> ##[1:2] !match_req[0];
	endproperty
	a_ie0: assert property (p_ie0) else $error("req 0 not masked");
	property p_ie1;
		wr && addr == 8'h20 && !wdata[CTRL_IE] |-> ##[1:2] !match_req[1];
	endproperty
	a_ie1: assert property (p_ie1) else $error("req 1 not masked");
	property p_keep;
		wr && addr == 8'h00 && wdata[2:1] == 2'h3 && match_req[0]
			|=> match_req[0] [*2];
	endproperty
	a_keep: assert property (p_keep) else $error("flag lost");
	property p_flag;
		s_req_held ##0 rd && addr == 8'h00 |=> rdata[2:1] == 2'h3;
	endproperty
	a_flag: assert property (p_flag) else $error("flag not read");
	property p_ctl; rd && addr == 8'h00 |=> rdata[31:7] == 25'h0; endproperty
	a_ctl: assert property (p_ctl) else $error("ctrl spare bits");
	property p_pol; rd && addr == 8'h04 |=> rdata[31:8] == 24'h0; endproperty
	a_pol: assert property (p_pol) else $error("polarity width");
	property p_cyc; rd && addr == 8'h08 |=> rdata[31:10] == 22'h0; endproperty
	a_cyc: assert property (p_cyc) else $error("cycle width");
endmodule
bind pwm_timer pwm_timer_asserts pwm_timer_asserts_inst (.clk, .rst_n,
	.addr, .wdata, .wr, .rd, .rdata, .chan1_out, .chan2_out, .match_req);
`default_nettype wire

// >>> dv/pwm_timer_tb.sv
// testbench: registers, waveform and match flag of the pwm timer
`timescale 1ns/1ps
`default_nettype none
module pwm_timer_tb;
	import pwm_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0]  chan1_out;
	logic [7:0]  chan2_out;
	logic [1:0]  match_req;
	logic [15:0] high_len;
	logic [15:0] period;
	logic [31:0] got;
	int          fails = 0;
	int          samples_checked = 0;
	// rows: address, write value, value read back
	logic [7:0]  row_a [8] = '{8'h04, 8'h24, 8'h08, 8'h10, 8'h14, 8'h40,
		8'h00, 8'h20};
	logic [31:0] row_w [8] = '{32'h1FF, 32'hF, 32'hFFFF, 32'h8003,
		32'h1234, 32'h55, 32'h70, 32'h10};
	logic [31:0] row_e [8] = '{32'hFF, 32'hF, 32'h3FF, 32'h8003, 32'h0,
		32'h0, 32'h70, 32'h10};
	always #2.5 clk = ~clk;
	pwm_timer pwm_timer_inst (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
		.chan1_out, .chan2_out, .match_req);
	pwm_load pwm_load_inst (.clk, .rst_n, .pin(chan1_out[0]), .high_len,
		.period);
	task automatic chk(input string what, input logic [31:0] exp, act);
		samples_checked++;
		if (act !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, act);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		wrap_up;
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(8'h08);
		chk("cycle reset", 32'h3FF, got);
		rd_reg(8'h0C);
		chk("count idle", 32'h0, got);
		chk("pins idle", 32'h0, {16'h0, chan1_out, chan2_out});
		foreach (row_a[i]) begin
			wr_reg(row_a[i], row_w[i]);
			rd_reg(row_a[i]);
			chk("row read", row_e[i], got);
		end
		// setup before start
		// channel 0: period 10, a and b high until count 3
		wr_reg(8'h04, 32'h0);
		wr_reg(8'h08, 32'h9);
		wr_reg(8'h10, 32'h8003);
		wr_reg(8'h11, 32'h5);
		wr_reg(8'h00, 32'h1);
		repeat (40) @(posedge clk);
		chk("high len", 32'd4, {16'h0, high_len});
		chk("period", 32'd10, {16'h0, period});
		// channel 1 pins show only its polarity word from the rows
		chk("unselected", 32'h0F, {18'h0, chan1_out[7:2], chan2_out});
		rd_reg(8'h00);
		chk("flag", 32'h5, got);
		chk("req masked", 32'h0, {30'h0, match_req});
		wr_reg(8'h00, 32'h7);
		repeat (3) @(posedge clk);
		chk("req", 32'h1, {30'h0, match_req});
		// buffer write in the cycle right after a match
		@(posedge chan1_out[0]);
		addr <= 8'h10;
		wdata <= 32'h8001;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		rd_reg(8'h18);
		chk("conflict duty", 32'h8001, got);
		repeat (2) @(posedge clk);
		chk("conflict high", 32'd2, {16'h0, high_len});
		// buffer restored well before next match
		wr_reg(8'h10, 32'h8003);
		wr_reg(8'h04, 32'hFF);
		repeat (40) @(posedge clk);
		chk("inverted high", 32'd6, {16'h0, high_len});
		wr_reg(8'h00, 32'h17);
		rd_reg(8'h00);
		chk("ctrl", 32'h17, got);
		repeat (60) @(posedge clk);
		chk("slow period", 32'd20, {16'h0, period});
		wrap_up;
	end
endmodule
`default_nettype wire

// >>> inc/chan_if.sv
// interface: register access from top to one channel
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
	logic        wr;
	logic [4:0]  ofs;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [7:0]  pwm;
	logic        irq;
	modport top  (output wr, ofs, wdata, input rdata, pwm, irq);
	modport chan (input wr, ofs, wdata, output rdata, pwm, irq);
endinterface
`default_nettype wire

// >>> inc/pwm_pkg.sv
// package: register map, field layout and constants of the pwm timer
package pwm_pkg;
	localparam int          NUM_CHAN    = 2;
	localparam int          NUM_OUT     = 8;
	localparam int          NUM_DUTY    = 4;
	localparam int          CNT_W       = 10;
	localparam int          ADDR_W      = 8;
	// per-channel register block, stride in bytes
	localparam logic [7:0]  CHAN_STRIDE = 8'h20;
	localparam logic [4:0]  OFS_CTRL    = 5'h00;
	localparam logic [4:0]  OFS_POL     = 5'h04;
	localparam logic [4:0]  OFS_CYCLE   = 5'h08;
	localparam logic [4:0]  OFS_COUNT   = 5'h0C;
	localparam logic [4:0]  OFS_BUF0    = 5'h10;
	localparam logic [4:0]  OFS_DUTY0   = 5'h18;
	// control register fields
	localparam int          CTRL_START  = 0;
	localparam int          CTRL_IE     = 1;
	localparam int          CTRL_FLAG   = 2;
	localparam int          CTRL_CKS_LO = 4;
	localparam int          CKS_W       = 3;
	// duty field layout: compare value low, select bit above
	localparam int          DUTY_SEL    = 15;
	localparam logic [31:0] RST_DUTY    = 32'h0000_0000;
	localparam logic [CNT_W-1:0] RST_CYCLE = 10'h3FF;
	// prescaler divide ratios are 2**cks
	localparam int          PRE_W       = 7;
endpackage

// >>> verilog/pwm_channel.sv
// one pwm channel: counter, cycle match, buffered duties, eight outputs
`timescale 1ns/1ps
`default_nettype none
module pwm_channel (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// register port from top
	chan_if.chan      bus
);
	import pwm_pkg::*;
	typedef struct packed {
		logic                 start;
		logic                 ie;
		logic                 flag;
		logic [CKS_W-1:0]     cks;
		logic [NUM_OUT-1:0]   pol;
		logic [CNT_W-1:0]     cycle;
		logic [CNT_W-1:0]     cnt;
		logic [NUM_DUTY-1:0][31:0] buffer;
		logic [NUM_DUTY-1:0][31:0] duty;
		logic [NUM_OUT-1:0]   wave;
		logic                 after_match;
		logic [NUM_OUT-1:0]   pwm;
		logic                 irq;
	} chan_t;
	chan_t s_q;
	chan_t s_d;
	logic  tick;
	logic  match;
	logic  [31:0] rd_word;

	pwm_prescaler u_pre (
		.clk   (clk),
		.rst_n (rst_n),
		.run   (s_q.start),
		.sel   (s_q.cks),
		.tick  (tick)
	);

	// pair of outputs per duty: field k drives a and b, outputs 2k and 2k+1
	function automatic logic [1:0] duty_of(input int k);
		return 2'(k >> 1);
	endfunction

	// register writes, counting and waveform generation
	always_comb begin
		s_d = s_q;
		s_d.after_match = 1'b0;
		match = s_q.start && tick && (s_q.cnt == s_q.cycle);
		if (s_q.start && tick) begin
			s_d.cnt = match ? '0 : s_q.cnt + 1'b1;
		end
		if (bus.wr && bus.ofs == OFS_CTRL) begin
			s_d.start = bus.wdata[CTRL_START];
			s_d.ie = bus.wdata[CTRL_IE];
			s_d.cks = bus.wdata[CTRL_CKS_LO +: CKS_W];
			if (!bus.wdata[CTRL_FLAG]) s_d.flag = 1'b0;
		end
		if (bus.wr && bus.ofs == OFS_POL) s_d.pol = bus.wdata[NUM_OUT-1:0];
		if (bus.wr && bus.ofs == OFS_CYCLE) s_d.cycle = bus.wdata[CNT_W-1:0];
		for (int i = 0; i < NUM_DUTY; i++) begin
			if (bus.wr && bus.ofs == OFS_BUF0 + 5'(i)) begin
				s_d.buffer[i] = bus.wdata;
				if (s_q.after_match) s_d.duty[i] = bus.wdata;
			end
		end
		// duty match drives the wave of its output pair low, before the polarity word is applied
		for (int o = 0; o < NUM_OUT; o++) begin
			if (s_q.start && tick
			    && s_q.cnt == s_q.duty[duty_of(o)][CNT_W-1:0]) begin
				s_d.wave[o] = 1'b0;
			end
		end
		if (match) begin
			s_d.after_match = 1'b1;
			s_d.duty = s_q.buffer;
			s_d.flag = 1'b1;
			for (int o = 0; o < NUM_OUT; o++) begin
				s_d.wave[o] = s_q.buffer[duty_of(o)][DUTY_SEL];
			end
		end
		s_d.pwm = s_d.wave ^ s_q.pol;
		s_d.irq = s_d.flag && s_d.ie;
		// read word for the top, which registers it on the strobe
		unique case (bus.ofs)
			OFS_CTRL:  rd_word = 32'({s_q.cks, 1'b0, s_q.flag,
			                            s_q.ie, s_q.start});
			OFS_POL:   rd_word = 32'(s_q.pol);
			OFS_CYCLE: rd_word = 32'(s_q.cycle);
			OFS_COUNT: rd_word = 32'(s_q.cnt);
			5'h10, 5'h11, 5'h12, 5'h13:
				rd_word = s_q.buffer[bus.ofs[1:0]];
			5'h18, 5'h19, 5'h1A, 5'h1B:
				rd_word = s_q.duty[bus.ofs[1:0]];
			default:   rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.cycle <= RST_CYCLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign bus.rdata = rd_word;
	assign bus.pwm = s_q.pwm;
	assign bus.irq = s_q.irq;
endmodule
`default_nettype wire

// >>> verilog/pwm_prescaler.sv
// prescaler: counting tick selected by a three-bit divider code
`timescale 1ns/1ps
`default_nettype none
module pwm_prescaler (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	// control
	input  wire logic                      run,
	input  wire logic [pwm_pkg::CKS_W-1:0] sel,
	// tick
	output logic                           tick
);
	import pwm_pkg::*;
	typedef struct packed {
		logic [PRE_W-1:0] div;
		logic             tick;
	} pre_t;
	pre_t s_q;
	pre_t s_d;
	logic [PRE_W-1:0] mask;

	// tick when the low sel bits of the divider are all ones
	always_comb begin
		s_d = s_q;
		mask = PRE_W'((1 << sel) - 1);
		s_d.tick = run && ((s_q.div & mask) == mask);
		s_d.div = run ? s_q.div + 1'b1 : '0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign tick = s_q.tick;
endmodule
`default_nettype wire

// >>> verilog/pwm_timer.sv
// top: two buffered pwm channels behind a plain register port
`timescale 1ns/1ps
`default_nettype none
module pwm_timer (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst_n,
	// register port
	input  wire logic [pwm_pkg::ADDR_W-1:0]   addr,
	input  wire logic [31:0]                  wdata,
	input  wire logic                         wr,
	input  wire logic                         rd,
	output logic      [31:0]                  rdata,
	// pwm pins and requests
	output logic      [pwm_pkg::NUM_OUT-1:0]  chan1_out,
	output logic      [pwm_pkg::NUM_OUT-1:0]  chan2_out,
	output logic      [pwm_pkg::NUM_CHAN-1:0] match_req
);
	import pwm_pkg::*;
	typedef struct packed {
		logic [31:0] rdata;
	} top_t;
	top_t s_q;
	top_t s_d;
	logic [NUM_CHAN-1:0][31:0] ch_rdata;
	logic [NUM_CHAN-1:0][7:0]  ch_pwm;
	logic [NUM_CHAN-1:0]       ch_irq;

	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_ch
		chan_if cif ();
		assign cif.wr = wr && addr[7:5] == 3'(c);
		assign cif.ofs = addr[4:0];
		assign cif.wdata = wdata;
		assign ch_rdata[c] = cif.rdata;
		assign ch_pwm[c] = cif.pwm;
		assign ch_irq[c] = cif.irq;
		pwm_channel u_ch (
			.clk   (clk),
			.rst_n (rst_n),
			.bus   (cif.chan)
		);
	end

	// capture the addressed channel's word on the read strobe; zero
	// otherwise, so the word stands one cycle and unmapped reads give 0
	always_comb begin
		s_d = s_q;
		s_d.rdata = 32'h0000_0000;
		for (int k = 0; k < NUM_CHAN; k++) begin
			if (rd && addr[7:5] == 3'(k)) s_d.rdata = ch_rdata[k];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// read data straight from the register
	assign rdata = s_q.rdata;
	assign chan1_out = ch_pwm[0];
	assign chan2_out = ch_pwm[1];
	assign match_req = ch_irq;
endmodule
`default_nettype wire
